// >>> fpsc_front_panel_scan_controller.sv
// Front panel scan controller: refreshes a multiplexed gas discharge
// display one cathode at a time and snapshots the panel switches.
// Assumes anode/cathode driver chips and two cascaded parallel-to-serial
// switch registers outside; frame data arrives from logic on clk.
//
// Notes on behaviour
// - Display has 24 cathode buses by 20 anode buses; one pair per segment.
// - Scan cathodes one at a time, driving that cathode's anode pattern.
// - Each step sends anode data and latches it before cathode data.
// - After the anode latch, shift cathode stream, then toggle display enable.
// - Repeat the sequence for all 24 cathodes to make one frame.
// - Pace the steps for about 70 frames per second.
// - Periodically capture all panel switches into two cascaded shift registers.
// - After each capture, shift the switch bits serially into the controller.
// - Snapshot covers two dual encoders, pulls, four buttons, volumes, power.
// - Display drive intensity follows the digitised ambient light level.
`timescale 1ns/100ps
module fpsc_front_panel_scan_controller
   import fpsc_pkg::*;
#(
   parameter int STEP_CYCLES_P = fpsc_pkg::STEP_CYCLES,
   parameter int SW_PERIOD_P = fpsc_pkg::SW_PERIOD_CYCLES,
   parameter int HALF_P = fpsc_pkg::HALF_CYCLES
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Frame buffer row updates.
   input wire logic rowValid,
   output logic rowReady,
   input wire logic [fpsc_pkg::IDX_W-1:0] rowIndex,
   input wire logic [fpsc_pkg::ANODES-1:0] rowAnodes,
   // Digitised ambient light level.
   input wire logic [7:0] ambientLevel,
   // Anode driver.
   output logic anodeClk,
   output logic anodeData,
   output logic anodeLatch,
   // Cathode driver.
   output logic cathodeClk,
   output logic cathodeData,
   output logic displayEnable,
   // Display drive intensity.
   output logic intensityPwm,
   // Switch shift registers.
   output logic swLoadN,
   output logic swClk,
   input wire logic swSerialIn,
   // Switch snapshot and frame status.
   output logic [fpsc_pkg::SW_BITS-1:0] swSnapshot,
   output logic swValid,
   output logic frameDone
);
   import fpsc_pkg::*;

   localparam int SEQ_CYCLES = (ANODES + CATHODES + 2) * 2 * HALF_P + 8;
   localparam int SW_SEQ_CYCLES = (SW_BITS + 2) * 2 * HALF_P + 8;
   localparam int HW = $clog2(HALF_P + 1);
   localparam int STW = $clog2(STEP_CYCLES_P + 1);
   localparam int SPW = $clog2(SW_PERIOD_P + 1);

   if (HALF_P < 3) begin : g_bad_half
      $error("fpsc: HALF_P must be at least 3 for the input synchroniser");
   end
   if (STEP_CYCLES_P < SEQ_CYCLES) begin : g_bad_step
      $error("fpsc: STEP_CYCLES_P too short for one cathode sequence");
   end
   if (SW_PERIOD_P < SW_SEQ_CYCLES) begin : g_bad_swp
      $error("fpsc: SW_PERIOD_P too short for one switch readout");
   end

   fpsc_disp_state_t dispState;
   fpsc_sw_state_t swState;

   logic [HW-1:0] halfCnt;
   logic tick;
   logic [STW-1:0] stepCnt;
   logic stepTick;
   logic [SPW-1:0] swCnt;
   logic swTick;

   logic [ANODES-1:0] frameMem [0:CATHODES-1];
   logic [IDX_W-1:0] cathIdx;

   logic fifoOutValid;
   logic fifoOutReady;
   logic [FIFO_W-1:0] fifoOutData;
   logic [IDX_W-1:0] drainIdx;

   logic anStart;
   logic anDone;
   logic cathStart;
   logic cathDone;
   logic swStart;
   logic swDone;
   logic [SW_BITS-1:0] swRxWord;
   logic swInMeta;
   logic swInSync;

   logic [7:0] pwmCnt;
   logic [7:0] driveLevel;

   // Pacing dividers.
   always_ff @(posedge clk)
   begin
      if (sys_rst || halfCnt == HW'(HALF_P - 1))
      begin
         halfCnt <= '0;
      end
      else
      begin
         halfCnt <= halfCnt + 1'b1;
      end
   end
   assign tick = (halfCnt == HW'(HALF_P - 1));

   // One step per cathode, 24 steps per frame, for about 70 frames/s.
   always_ff @(posedge clk)
   begin
      if (sys_rst || stepTick)
      begin
         stepCnt <= '0;
      end
      else
      begin
         stepCnt <= stepCnt + 1'b1;
      end
   end
   assign stepTick = (stepCnt == STW'(STEP_CYCLES_P - 1));

   always_ff @(posedge clk)
   begin
      if (sys_rst || swTick)
      begin
         swCnt <= '0;
      end
      else
      begin
         swCnt <= swCnt + 1'b1;
      end
   end
   assign swTick = (swCnt == SPW'(SW_PERIOD_P - 1));

   // Row updates pass through the FIFO; the drain stalls while the scan
   // reads the frame memory so the read never sees a half-written row.
   fpsc_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .inValid(rowValid),
      .inReady(rowReady),
      .inData({rowIndex, rowAnodes}),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   assign fifoOutReady = (dispState != DS_FETCH);
   assign drainIdx = fifoOutData[FIFO_W-1:ANODES];

   // Rows addressed past the last cathode are dropped.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < CATHODES; i++)
         begin
            frameMem[i] <= ANODE_RESET;
         end
      end
      else if (fifoOutValid && fifoOutReady &&
               drainIdx < IDX_W'(CATHODES))
      begin
         frameMem[drainIdx] <= fifoOutData[ANODES-1:0];
      end
   end

   // Display step sequencer.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         dispState <= DS_WAIT;
         anodeLatch <= 1'b0;
         displayEnable <= 1'b0;
      end
      else
      begin
         case (dispState)
            DS_WAIT:
            begin
               if (stepTick)
               begin
                  dispState <= DS_FETCH;
               end
            end
            DS_FETCH:
            begin
               dispState <= DS_ANODE;
            end
            DS_ANODE:
            begin
               if (anDone)
               begin
                  anodeLatch <= 1'b1;
                  dispState <= DS_LATCH;
               end
            end
            DS_LATCH:
            begin
               if (tick)
               begin
                  anodeLatch <= 1'b0;
                  dispState <= DS_CATHODE;
               end
            end
            DS_CATHODE:
            begin
               if (cathDone)
               begin
                  displayEnable <= ~displayEnable;
                  dispState <= DS_WAIT;
               end
            end
            default:
            begin
               dispState <= DS_WAIT;
            end
         endcase
      end
   end

   // Cathode index walks all cathodes, then marks the end of a frame.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cathIdx <= IDX_RESET;
         frameDone <= 1'b0;
      end
      else
      begin
         frameDone <= 1'b0;
         if (dispState == DS_CATHODE && cathDone)
         begin
            if (cathIdx == IDX_W'(CATHODES - 1))
            begin
               cathIdx <= IDX_RESET;
               frameDone <= 1'b1;
            end
            else
            begin
               cathIdx <= cathIdx + 1'b1;
            end
         end
      end
   end

   assign anStart = (dispState == DS_FETCH);
   assign cathStart = (dispState == DS_LATCH) && tick;

   fpsc_serial_shift #(
      .WIDTH(ANODES)
   ) u_anode_shift (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .start(anStart),
      .txWord(frameMem[cathIdx]),
      .busy(),
      .done(anDone),
      .rxWord(),
      .sclk(anodeClk),
      .sdo(anodeData),
      .sdi(1'b0)
   );

   fpsc_serial_shift #(
      .WIDTH(CATHODES)
   ) u_cathode_shift (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .start(cathStart),
      .txWord(cathode_select(cathIdx)),
      .busy(),
      .done(cathDone),
      .rxWord(),
      .sclk(cathodeClk),
      .sdo(cathodeData),
      .sdi(1'b0)
   );

   // The switch serial line comes from off-chip.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         swInMeta <= 1'b0;
         swInSync <= 1'b0;
      end
      else
      begin
         swInMeta <= swSerialIn;
         swInSync <= swInMeta;
      end
   end

   // Switch snapshot: one load pulse lasting until the next tick (at most a half serial period), then shift.
   // A capture request while a readout runs is skipped, not queued.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         swState <= SW_IDLE;
         swLoadN <= 1'b1;
         swSnapshot <= SW_RESET;
         swValid <= 1'b0;
      end
      else
      begin
         swValid <= 1'b0;
         case (swState)
            SW_IDLE:
            begin
               if (swTick)
               begin
                  swLoadN <= 1'b0;
                  swState <= SW_LOAD;
               end
            end
            SW_LOAD:
            begin
               if (tick)
               begin
                  swLoadN <= 1'b1;
                  swState <= SW_SHIFT;
               end
            end
            SW_SHIFT:
            begin
               if (swDone)
               begin
                  swSnapshot <= swRxWord;
                  swValid <= 1'b1;
                  swState <= SW_IDLE;
               end
            end
            default:
            begin
               swState <= SW_IDLE;
            end
         endcase
      end
   end

   assign swStart = (swState == SW_LOAD) && tick;

   fpsc_serial_shift #(
      .WIDTH(SW_BITS)
   ) u_switch_shift (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .start(swStart),
      .txWord(SW_RESET),
      .busy(),
      .done(swDone),
      .rxWord(swRxWord),
      .sclk(swClk),
      .sdo(),
      .sdi(swInSync)
   );

   // Intensity PWM follows ambient light, with a floor so the display
   // never goes fully dark in a dim cockpit.
   assign driveLevel = (ambientLevel < MIN_INTENSITY) ? MIN_INTENSITY :
                       ambientLevel;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pwmCnt <= 8'h00;
         intensityPwm <= 1'b0;
      end
      else
      begin
         pwmCnt <= pwmCnt + 1'b1;
         intensityPwm <= (pwmCnt < driveLevel);
      end
   end

endmodule : fpsc_front_panel_scan_controller

// >>> fpsc_pkg.sv
// Shared constants and types for the front panel scan controller.
// Assumes a single 50 MHz clock domain and a synchronous active-high reset.
package fpsc_pkg;

   // Clock and display geometry.
   localparam int CLK_HZ = 50_000_000;
   localparam int CATHODES = 24;
   localparam int ANODES = 20;
   localparam int IDX_W = 5;

   // Frame rate and the cycle count of one cathode step, rounded down.
   localparam int FRAME_HZ = 70;
   localparam int STEP_CYCLES = CLK_HZ / (FRAME_HZ * CATHODES);

   // Serial clock towards the drivers and switch registers.
   localparam int SCLK_HZ = 1_000_000;
   localparam int HALF_CYCLES = CLK_HZ / (2 * SCLK_HZ);

   // Switch snapshot period.
   localparam int SW_PERIOD_US = 10_000;
   localparam int SW_PERIOD_CYCLES = (CLK_HZ / 1_000_000) * SW_PERIOD_US;

   // Two cascaded 12-bit parallel-to-serial registers.
   localparam int SW_BITS = 24;

   // Snapshot bit positions; each rotary step direction pair takes 2 bits.
   localparam int SWB_ROT_LEFT_OUTER = 0;
   localparam int SWB_ROT_LEFT_INNER = 2;
   localparam int SWB_ROT_RIGHT_OUTER = 4;
   localparam int SWB_ROT_RIGHT_INNER = 6;
   localparam int SWB_PULL_LEFT = 8;
   localparam int SWB_PULL_RIGHT = 9;
   localparam int SWB_BUTTON0 = 10;
   localparam int SWB_VOL_PULL_COM = 14;
   localparam int SWB_VOL_PULL_NAV = 15;
   localparam int SWB_POWER = 16;

   // Buffering between the frame buffer writer and the frame memory.
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = IDX_W + ANODES;

   // Reset and limit values.
   localparam logic [7:0] MIN_INTENSITY = 8'h10;
   localparam logic [IDX_W-1:0] IDX_RESET = 5'h00;
   localparam logic [ANODES-1:0] ANODE_RESET = 20'h00000;
   localparam logic [SW_BITS-1:0] SW_RESET = 24'h000000;

   typedef enum logic [2:0]
   {
      DS_WAIT,
      DS_FETCH,
      DS_ANODE,
      DS_LATCH,
      DS_CATHODE
   } fpsc_disp_state_t;

   typedef enum logic [1:0]
   {
      SW_IDLE,
      SW_LOAD,
      SW_SHIFT
   } fpsc_sw_state_t;

   // One-hot cathode select word for a cathode index.
   function automatic logic [CATHODES-1:0] cathode_select
   (
      input logic [IDX_W-1:0] idx
   );
      logic [CATHODES-1:0] word;
      word = '0;
      word[idx] = 1'b1;
      return word;
   endfunction : cathode_select

endpackage : fpsc_pkg

// >>> fpsc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset; depth a power of two.
`timescale 1ns/100ps
module fpsc_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 8
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Filling side.
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side.
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fpsc_fifo: DEPTH must be a power of two, at least 2");
   end

   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop)
         begin
            rdPtr <= rdPtr + 1'b1;
         end
         if (push && !pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop && !push)
         begin
            count <= count - 1'b1;
         end
      end
   end

endmodule : fpsc_fifo

// >>> fpsc_serial_shift.sv
// Serial shifter: sends a word MSB first and gathers a word from sdi.
// Assumes tick is a one-cycle pulse per half serial clock period and that
// sdi is already synchronised to clk.
`timescale 1ns/100ps
module fpsc_serial_shift #(
   parameter int WIDTH = 20
)
(
   // Clock, reset and pacing.
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   // Word request.
   input wire logic start,
   input wire logic [WIDTH-1:0] txWord,
   output logic busy,
   output logic done,
   output logic [WIDTH-1:0] rxWord,
   // Serial pins.
   output logic sclk,
   output logic sdo,
   input wire logic sdi
);
   localparam int CW = $clog2(WIDTH + 1);

   logic [WIDTH-1:0] shreg;
   logic [CW-1:0] bitsLeft;
   logic sampled;

   if (WIDTH < 2) begin : g_bad_width
      $error("fpsc_serial_shift: WIDTH must be at least 2");
   end

   // Data changes while sclk is low; the far side samples on the rise.
   // The incoming bit is taken at the rise too, because parallel-load
   // registers move their next bit out on that same edge.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         busy <= 1'b0;
         done <= 1'b0;
         sclk <= 1'b0;
         sdo <= 1'b0;
         sampled <= 1'b0;
         shreg <= '0;
         bitsLeft <= '0;
         rxWord <= '0;
      end
      else
      begin
         done <= 1'b0;
         if (!busy && start)
         begin
            busy <= 1'b1;
            shreg <= txWord;
            sdo <= txWord[WIDTH-1];
            bitsLeft <= CW'(WIDTH);
            sclk <= 1'b0;
         end
         else if (busy && tick)
         begin
            if (!sclk)
            begin
               sclk <= 1'b1;
               sampled <= sdi;
            end
            else
            begin
               sclk <= 1'b0;
               shreg <= {shreg[WIDTH-2:0], sampled};
               sdo <= shreg[WIDTH-2];
               bitsLeft <= bitsLeft - 1'b1;
               if (bitsLeft == CW'(1))
               begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  sdo <= 1'b0;
                  rxWord <= {shreg[WIDTH-2:0], sampled};
               end
            end
         end
      end
   end

endmodule : fpsc_serial_shift

// >>> fpsc_front_panel_scan_controller_asserts.sv
// Checker for the scan controller ports: display and switch link order.
// Assumes the shortened step count is handed on by the bind below.
`timescale 1ns/100ps
module fpsc_scan_checker #(
   parameter int STEP_CYCLES_P = 2500
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Display link.
   input wire logic anodeClk,
   input wire logic anodeLatch,
   input wire logic cathodeClk,
   input wire logic cathodeData,
   input wire logic displayEnable,
   input wire logic frameDone,
   // Switch link.
   input wire logic swLoadN,
   input wire logic swClk,
   input wire logic swValid
);
   logic prevA, prevC, prevS, prevEn, seen, latched;
   int gap, aBits, cBits, cOnes, steps, swBits;
   logic toggle, aRise, cRise, sRise;
   assign toggle = displayEnable != prevEn;
   assign aRise = anodeClk && !prevA;
   assign cRise = cathodeClk && !prevC;
   assign sRise = swClk && !prevS;
   // gap, aBits, cBits and cOnes restart at the enable flip that closes a step; steps restarts at frameDone, swBits at the switch load.
   always_ff @(posedge clk)
   begin
      {prevA, prevC, prevS, prevEn} <= sys_rst ? 4'h0 :
         {anodeClk, cathodeClk, swClk, displayEnable};
      seen <= !sys_rst && (seen || toggle);
      latched <= !sys_rst && !toggle && (latched || anodeLatch);
      gap <= (sys_rst || toggle) ? 0 : gap + 1;
      aBits <= (sys_rst || toggle) ? 0 : aBits + int'(aRise);
      cBits <= (sys_rst || toggle) ? 0 : cBits + int'(cRise);
      cOnes <= (sys_rst || toggle) ? 0 : cOnes + int'(cRise && cathodeData);
      steps <= (sys_rst || frameDone) ? 0 : steps + int'(toggle);
      swBits <= (sys_rst || !swLoadN) ? 0 : swBits + int'(sRise);
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_step_spacing: assert property
      (toggle && seen |-> gap == STEP_CYCLES_P - 1)
      else $error("display enable spacing wrong");
   a_anode_bits: assert property ($rose(anodeLatch) |-> aBits == 20)
      else $error("anode word length wrong at latch");
   a_latch_quiet: assert property
      (anodeLatch |-> !anodeClk && !cathodeClk)
      else $error("serial clock active during latch");
   a_latch_first: assert property (cRise |-> latched)
      else $error("cathode bit before anode latch");
   a_cathode_bits: assert property
      (toggle |-> cBits == 24 && !cathodeClk)
      else $error("enable flip before full cathode word");
   a_cathode_onehot: assert property (toggle |-> cOnes == 1)
      else $error("cathode word not one-hot");
   a_frame_steps: assert property (frameDone |-> steps inside {23, 24})
      else $error("frame end after wrong step count");
   a_load_no_clock: assert property (!swLoadN |-> !swClk)
      else $error("switch clock during parallel load");
   a_switch_bits: assert property
      (swValid |-> swBits == 24 ##1 !swValid)
      else $error("switch readout length wrong");
   c_frame: cover property (frameDone);
   c_latch: cover property ($rose(anodeLatch));
   c_switch: cover property (swValid);
endmodule : fpsc_scan_checker

bind fpsc_front_panel_scan_controller fpsc_scan_checker #(
   .STEP_CYCLES_P(STEP_CYCLES_P)
) i_chk (
   .clk(clk),
   .sys_rst(sys_rst),
   .anodeClk(anodeClk),
   .anodeLatch(anodeLatch),
   .cathodeClk(cathodeClk),
   .cathodeData(cathodeData),
   .displayEnable(displayEnable),
   .frameDone(frameDone),
   .swLoadN(swLoadN),
   .swClk(swClk),
   .swValid(swValid)
);

// >>> fpsc_panel_model.sv
// Behavioural panel: anode and cathode drivers plus two switch registers.
// Assumes the controller's serial clocks idle low between words.
`timescale 1ns/100ps
module fpsc_panel_model
(
   // Display drivers.
   input wire logic anodeClk,
   input wire logic anodeData,
   input wire logic anodeLatch,
   input wire logic cathodeClk,
   input wire logic cathodeData,
   input wire logic displayEnable,
   // Switch registers.
   input wire logic swLoadN,
   input wire logic swClk,
   input wire logic [23:0] swState,
   output logic swSerialOut,
   // What the display shows.
   output logic [19:0] litAnodes,
   output logic [23:0] litCathodes,
   output int steps
);
   logic [19:0] aShift, aHeld;
   logic [23:0] cShift, swShift;
   initial steps = 0;
   always @(posedge anodeClk)
      aShift <= {aShift[18:0], anodeData};
   always @(posedge anodeLatch)
      aHeld <= aShift;
   always @(posedge cathodeClk)
      cShift <= {cShift[22:0], cathodeData};
   // Each enable flip lights the shifted cathode with the held anodes.
   always @(displayEnable)
   begin
      litAnodes <= aHeld;
      litCathodes <= cShift;
      steps <= steps + 1;
   end
   // The cascade input has a pull-up, so ones follow the last real bit.
   always @(posedge swClk or negedge swLoadN)
      if (!swLoadN)
         swShift <= swState;
      else
         swShift <= {swShift[22:0], 1'b1};
   assign swSerialOut = swShift[23];
endmodule : fpsc_panel_model

// >>> fpsc_front_panel_scan_controller_tb_top.sv
// Testbench for the scan controller with the panel model on its pins.
// Assumes shortened step, switch and serial counts; the step count is a
// multiple of the half serial period so every step has the same length.
`timescale 1ns/100ps
`define CHK(what, exp, got) begin nTests++; if ((got) !== (exp)) begin \
   nErrors++; $display("CHECK FAILED %s exp %0h seen %0h", what, exp, got); \
   end end
module fpsc_front_panel_scan_controller_tb_top;
   import fpsc_pkg::*;
   localparam int STEP = 402;
   localparam int SWP = 400;
   logic clk, sys_rst, rowValid, rowReady, swSerialIn, intensityPwm;
   logic anodeClk, anodeData, anodeLatch, cathodeClk, cathodeData;
   logic displayEnable, swLoadN, swClk, swValid, frameDone;
   logic [4:0] rowIndex;
   logic [19:0] rowAnodes, litAnodes;
   logic [23:0] swSnapshot, swState, litCathodes;
   logic [7:0] ambientLevel;
   int steps, frames, nErrors, nTests, base;

   fpsc_front_panel_scan_controller #(.STEP_CYCLES_P(STEP),
      .SW_PERIOD_P(SWP), .HALF_P(3)) i_dut (.clk(clk), .sys_rst(sys_rst),
      .rowValid(rowValid), .rowReady(rowReady), .rowIndex(rowIndex),
      .rowAnodes(rowAnodes), .ambientLevel(ambientLevel),
      .anodeClk(anodeClk), .anodeData(anodeData), .anodeLatch(anodeLatch),
      .cathodeClk(cathodeClk), .cathodeData(cathodeData),
      .displayEnable(displayEnable), .intensityPwm(intensityPwm),
      .swLoadN(swLoadN), .swClk(swClk), .swSerialIn(swSerialIn),
      .swSnapshot(swSnapshot), .swValid(swValid), .frameDone(frameDone));
   fpsc_panel_model i_panel (.anodeClk(anodeClk), .anodeData(anodeData),
      .anodeLatch(anodeLatch), .cathodeClk(cathodeClk),
      .cathodeData(cathodeData), .displayEnable(displayEnable),
      .swLoadN(swLoadN), .swClk(swClk), .swState(swState),
      .swSerialOut(swSerialIn), .litAnodes(litAnodes),
      .litCathodes(litCathodes), .steps(steps));
   function automatic logic [19:0] rowPat(int k);
      return 20'h81234 ^ (20'h00E25 * 20'(k));
   endfunction : rowPat

   task automatic testDone();
      if (nErrors == 0 && nTests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : testDone

   task automatic testRows();
      // Rows 24 and 31 must be dropped, not folded onto a real row.
      for (int k = 0; k < 26; k++)
      begin
         @(negedge clk);
         rowValid = 1'b1;
         rowIndex = (k < 24) ? 5'(k) : ((k == 24) ? 5'h18 : 5'h1F);
         rowAnodes = (k < 24) ? rowPat(k) : 20'hFFFFF;
         `CHK("rowReady", 1'b1, rowReady)
      end
      @(negedge clk);
      rowValid = 1'b0;
   endtask : testRows

   task automatic testFrame();
      int last;
      int gap;
      last = steps;
      frames = 0;
      for (int k = 0; k < 25; k++)
      begin
         gap = 0;
         while (steps == last && gap < 2 * STEP)
         begin
            @(negedge clk);
            gap++;
         end
         last = steps;
         if (k == 0)
            base = steps;
         `CHK("cathodes", 24'h000001 << (k % 24), litCathodes)
         `CHK("anodes", rowPat(k % 24), litAnodes)
         if (k > 0)
            `CHK("stepGap", STEP, gap)
      end
      `CHK("frames", 1, frames)
   endtask : testFrame

   task automatic waitSw();
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (swValid !== 1'b1 && n < 3 * SWP);
      `CHK("swValid", 1'b1, swValid)
   endtask : waitSw

   task automatic testSwitch(logic [23:0] val);
      swState = val;
      waitSw();
      waitSw();
      `CHK("snapshot", val, swSnapshot)
      `CHK("power", val[16], swSnapshot[SWB_POWER])
   endtask : testSwitch

   task automatic testPwm(logic [7:0] level, int expHigh);
      int cnt;
      ambientLevel = level;
      repeat (4) @(negedge clk);
      cnt = 0;
      repeat (256)
      begin
         @(negedge clk);
         if (intensityPwm === 1'b1)
            cnt++;
      end
      `CHK("pwmHigh", expHigh, cnt)
   endtask : testPwm

   task automatic testFifo();
      int last;
      int idx;
      // A burst of new rows while the scan runs must pass the FIFO whole.
      for (int k = 0; k < 24; k++)
      begin
         @(negedge clk);
         rowValid = 1'b1;
         rowIndex = 5'(k);
         rowAnodes = ~rowPat(k);
         `CHK("burstReady", 1'b1, rowReady)
      end
      @(negedge clk);
      rowValid = 1'b0;
      // The first step after the burst may have fetched an old row.
      for (int n = 0; n < 3; n++)
      begin
         last = steps;
         for (int t = 0; t < 2 * STEP && steps == last; t++)
            @(negedge clk);
         idx = (steps - base) % 24;
         if (n > 0)
         begin
            `CHK("newCathode", 24'h000001 << idx, litCathodes)
            `CHK("newAnodes", ~rowPat(idx), litAnodes)
         end
      end
   endtask : testFifo

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(negedge clk)
      if (frameDone === 1'b1)
         frames++;

   initial
   begin
      repeat (60000) @(posedge clk);
      nErrors++;
      testDone();
   end

   initial
   begin
      {nErrors, nTests} = '0;
      sys_rst = 1'b1;
      rowValid = 1'b0;
      rowIndex = 5'h00;
      rowAnodes = 20'h00000;
      ambientLevel = 8'h00;
      swState = 24'h000000;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      @(negedge clk);
      `CHK("loadIdle", 1'b1, swLoadN)
      `CHK("enableIdle", 1'b0, displayEnable)
      testRows();
      testFrame();
      testSwitch(24'h01A5C3);
      testSwitch(24'h00FE3C);
      testPwm(8'h00, 16);
      testPwm(8'hC0, 192);
      testFifo();
      testDone();
   end
endmodule : fpsc_front_panel_scan_controller_tb_top
